// ==== hw/lst_pkg.sv ====
// Constants of the local source table
`default_nettype none
package lst_pkg;
    // ==========================================
    // Entries and address map
    // ==========================================
    localparam int NUM_ENTRIES = 7;
    localparam int IDX_CERR = 0;
    localparam int IDX_TIMER = 1;
    localparam int IDX_THERM = 2;
    localparam int IDX_PERF = 3;
    localparam int IDX_PIN0 = 4;
    localparam int IDX_PIN1 = 5;
    localparam int IDX_ERR = 6;
    localparam logic [31:0] ADDR_CERR = 32'hfee002f0;
    localparam logic [31:0] ADDR_TIMER = 32'hfee00320;
    localparam logic [31:0] ADDR_THERM = 32'hfee00330;
    localparam logic [31:0] ADDR_PERF = 32'hfee00340;
    localparam logic [31:0] ADDR_PIN0 = 32'hfee00350;
    localparam logic [31:0] ADDR_PIN1 = 32'hfee00360;
    localparam logic [31:0] ADDR_ERR = 32'hfee00370;
    localparam logic [31:0] ADDR_VERSION = 32'hfee00030;
    localparam logic [NUM_ENTRIES-1:0][31:0] ENTRY_ADDR = {
        ADDR_ERR, ADDR_PIN1, ADDR_PIN0, ADDR_PERF, ADDR_THERM, ADDR_TIMER, ADDR_CERR};

    // ==========================================
    // Entry field layout
    // ==========================================
    localparam int VEC_LSB = 0;
    localparam int VEC_W = 8;
    localparam int MODE_LSB = 8;
    localparam int MODE_W = 3;
    localparam int STATUS_BIT = 12;
    localparam int POL_BIT = 13;
    localparam int REMOTE_BIT = 14;
    localparam int TRIG_BIT = 15;
    localparam int MASK_BIT = 16;
    localparam int TMODE_BIT = 17;
    localparam logic [31:0] ENTRY_RESET = 32'h00010000;
    // Writable bits per entry class
    localparam logic [31:0] WR_PIN = 32'h0001a7ff;
    localparam logic [31:0] WR_TIMER = 32'h000300ff;
    localparam logic [31:0] WR_ERR = 32'h000100ff;
    localparam logic [31:0] WR_OTHER = 32'h000107ff;
    localparam logic [NUM_ENTRIES-1:0][31:0] ENTRY_WR = {
        WR_ERR, WR_PIN, WR_PIN, WR_OTHER, WR_OTHER, WR_TIMER, WR_OTHER};
    localparam logic [7:0] VEC_FIRST_VALID = 8'h10;

    // ==========================================
    // Version register layout
    // ==========================================
    localparam int VER_LSB = 0;
    localparam int LAST_IDX_LSB = 16;
    localparam int EOI_SUPP_BIT = 24;
    localparam logic [7:0] VER_RESERVED_FIRST = 8'h20;

    // ==========================================
    // Delivery modes
    // ==========================================
    typedef enum logic [2:0] {
        LST_MODE_FIXED = 3'b000,
        LST_MODE_MGMT = 3'b010,
        LST_MODE_NMI = 3'b100,
        LST_MODE_INIT = 3'b101,
        LST_MODE_EXT = 3'b111
    } lst_mode_t;
endpackage
`default_nettype wire

// ==== hw/lst_table.sv ====
// Local source table: entries, sensing, delivery to the core
//
// How it works
// - Hardwired version, never a reserved code
// - Last entry index equals entries minus one
// - Version flag: end-of-interrupt broadcast suppressible
// - One 32-bit register per local source
// - Thermal entry optional, fixed slot address
// - Each local pin delivers through its entry
// - Mode 000 vector, 010 management interrupt
// - Mode 100 non-maskable, vector ignored
// - Mode 101 init request, vector zero advised
// - Mode 111 external controller supplies vector
// - Status bit set until core accepts
// - Polarity 0 active high, 1 active low
// - Level fixed: remote flag until end-of-interrupt
// - Pin trigger bit: edge 0, level 1
// - Non-fixed modes and timer/error forced sensing
// - No external controller: fixed forced level
// - Mask 0 allows, 1 blocks
// - Performance entry self-masks when handled
// - Timer mode bit: one-shot 0, periodic 1
// - Vectors 16 to 255 valid
// - Vectors 0 to 15 flag illegal
// - Writing illegal fixed vector flags error
// - Reset clears entries, sets masks
// - Software-disabled forces all masks set
`default_nettype none
module lst_table #(
    parameter int HAS_THERMAL = 1,
    parameter logic [7:0] VERSION_CODE = 8'h1c, // Arbitrary value
    parameter logic EOI_SUPPRESS_OK = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [31:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    input wire logic sw_enable_i,
    input wire logic no_io_ctrl_i,
    input wire logic timer_evt_i,
    input wire logic thermal_evt_i,
    input wire logic perf_evt_i,
    input wire logic error_evt_i,
    input wire logic corrected_error_threshold_irq_i,
    input wire logic local_irq_pin0_i,
    input wire logic local_irq_pin1_i,
    output logic irq_valid_o,
    output logic [7:0] irq_vector_o,
    output lst_pkg::lst_mode_t irq_mode_o,
    output logic [2:0] irq_src_o,
    input wire logic irq_accept_i,
    output logic acknowledge_cycle_o,
    input wire logic end_of_interrupt_message_i,
    input wire logic [7:0] eoi_vector_i,
    output logic illegal_vector_o,
    output logic timer_periodic_o
);
    import lst_pkg::*;

    // Elaboration checks on the parameters
    if (HAS_THERMAL < 0 || HAS_THERMAL > 1) begin : g_bad_thermal
        $error("HAS_THERMAL must be 0 or 1");
    end
    if (VERSION_CODE >= VER_RESERVED_FIRST) begin : g_bad_version
        $error("VERSION_CODE lies in the reserved range");
    end

    localparam int IMPL_ENTRIES = NUM_ENTRIES - 1 + HAS_THERMAL;
    localparam logic [7:0] LAST_INDEX = 8'(IMPL_ENTRIES - 1);

    // ==========================================
    // Pin synchronisers
    // ==========================================
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic [1:0] pin_act_d;

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
        end else begin
            pin_meta <= {local_irq_pin1_i, local_irq_pin0_i};
            pin_sync <= pin_meta;
        end
    end

    // ==========================================
    // Entry storage and decode
    // ==========================================
    logic [NUM_ENTRIES-1:0][31:0] ent;
    logic [NUM_ENTRIES-1:0] pending;
    logic [NUM_ENTRIES-1:0] remote;
    logic [NUM_ENTRIES-1:0] impl;
    logic [NUM_ENTRIES-1:0] hit;
    logic [NUM_ENTRIES-1:0] set_req;
    logic [NUM_ENTRIES-1:0] wr_illegal;
    logic [NUM_ENTRIES-1:0] lvl;
    logic [NUM_ENTRIES-1:0] active;
    logic [NUM_ENTRIES-1:0] evt;
    logic take;
    logic ver_hit;

    assign take = irq_valid_o && irq_accept_i;
    assign ver_hit = (reg_addr_i == ADDR_VERSION);
    assign evt[IDX_CERR] = corrected_error_threshold_irq_i;
    assign evt[IDX_TIMER] = timer_evt_i;
    assign evt[IDX_THERM] = thermal_evt_i;
    assign evt[IDX_PERF] = perf_evt_i;
    assign evt[IDX_ERR] = error_evt_i;
    assign evt[IDX_PIN0] = 1'b0;
    assign evt[IDX_PIN1] = 1'b0;

    genvar g;
    generate
        for (g = 0; g < NUM_ENTRIES; g++) begin : g_ent
            logic [7:0] vec;
            logic [2:0] mode;
            logic legal;
            logic fixed;
            logic prev_act;
            assign impl[g] = (g != IDX_THERM) || (HAS_THERMAL == 1);
            assign hit[g] = impl[g] && (reg_addr_i == ENTRY_ADDR[g]);
            assign vec = ent[g][VEC_LSB +: VEC_W];
            assign mode = ent[g][MODE_LSB +: MODE_W];
            assign fixed = (mode == LST_MODE_FIXED);
            assign legal = impl[g] && (mode == LST_MODE_FIXED || mode == LST_MODE_MGMT
                || mode == LST_MODE_NMI || mode == LST_MODE_INIT || mode == LST_MODE_EXT)
                && !(fixed && vec < VEC_FIRST_VALID);
            if ((g == IDX_PIN0) || (g == IDX_PIN1)) begin : g_pin
                assign active[g] = pin_sync[g - IDX_PIN0] ^ ent[g][POL_BIT];
                assign prev_act = pin_act_d[g - IDX_PIN0];
                // Trigger bit only counts in fixed mode
                assign lvl[g] = (fixed && (ent[g][TRIG_BIT] || no_io_ctrl_i))
                    || (mode == LST_MODE_EXT);
            end else begin : g_evt
                assign active[g] = evt[g];
                // Event inputs are one-cycle pulses, each one an edge
                assign prev_act = 1'b0;
                assign lvl[g] = 1'b0;
            end
            // Masked or illegal sources never set pending
            assign set_req[g] = legal && !ent[g][MASK_BIT]
                && (lvl[g] ? (active[g] && !pending[g] && !(fixed && remote[g]))
                           : (active[g] && !prev_act));
            assign wr_illegal[g] = reg_wr_i && hit[g]
                && reg_wdata_i[MODE_LSB +: MODE_W] == LST_MODE_FIXED
                && reg_wdata_i[VEC_LSB +: VEC_W] < VEC_FIRST_VALID;
        end
    endgenerate

    // Previous pin levels for edge sensing
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            pin_act_d <= 2'h0;
        end else begin
            pin_act_d <= active[IDX_PIN1:IDX_PIN0];
        end
    end

    // ==========================================
    // Entry registers
    // ==========================================
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < NUM_ENTRIES; i++) begin
                ent[i] <= ENTRY_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_ENTRIES; i++) begin
                if (reg_wr_i && hit[i]) begin
                    ent[i] <= reg_wdata_i & ENTRY_WR[i];
                end
                if (!sw_enable_i) begin
                    ent[i][MASK_BIT] <= 1'b1;
                end
            end
            if (take && irq_src_o == 3'(IDX_PERF)) begin
                ent[IDX_PERF][MASK_BIT] <= 1'b1;
            end
        end
    end

    assign timer_periodic_o = ent[IDX_TIMER][TMODE_BIT];

    // ==========================================
    // Delivery status and remote flags
    // ==========================================
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            pending <= '0;
        end else begin
            for (int i = 0; i < NUM_ENTRIES; i++) begin
                if (set_req[i]) begin
                    pending[i] <= 1'b1;
                end else if (take && irq_src_o == 3'(i)) begin
                    pending[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            remote <= '0;
        end else begin
            for (int i = 0; i < NUM_ENTRIES; i++) begin
                if (take && irq_src_o == 3'(i) && irq_mode_o == LST_MODE_FIXED && lvl[i]) begin
                    remote[i] <= 1'b1;
                end else if (end_of_interrupt_message_i
                    && eoi_vector_i == ent[i][VEC_LSB +: VEC_W]) begin
                    remote[i] <= 1'b0;
                end
            end
        end
    end

    // ==========================================
    // Delivery to the core
    // ==========================================
    logic any_ready;
    logic [2:0] pick;
    logic [NUM_ENTRIES-1:0] ready;

    assign ready = pending & ~({NUM_ENTRIES{irq_valid_o}});

    always_comb begin
        any_ready = 1'b0;
        pick = 3'h0;
        for (int i = NUM_ENTRIES - 1; i >= 0; i--) begin
            if (ready[i]) begin
                any_ready = 1'b1;
                pick = 3'(i);
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            irq_valid_o <= 1'b0;
            irq_vector_o <= 8'h00;
            irq_mode_o <= LST_MODE_FIXED;
            irq_src_o <= 3'h0;
        end else if (take) begin
            irq_valid_o <= 1'b0;
        end else if (!irq_valid_o && any_ready) begin
            irq_valid_o <= 1'b1;
            irq_src_o <= pick;
            irq_mode_o <= lst_mode_t'(ent[pick][MODE_LSB +: MODE_W]);
            // Only fixed mode carries the programmed vector
            irq_vector_o <= (ent[pick][MODE_LSB +: MODE_W] == LST_MODE_FIXED)
                ? ent[pick][VEC_LSB +: VEC_W] : 8'h00;
        end
    end

    // External controller answers the acknowledge and supplies the vector
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            acknowledge_cycle_o <= 1'b0;
        end else begin
            acknowledge_cycle_o <= take && irq_mode_o == LST_MODE_EXT;
        end
    end

    // ==========================================
    // Illegal vector indication
    // ==========================================
    logic evt_illegal;

    always_comb begin
        evt_illegal = 1'b0;
        for (int i = 0; i < NUM_ENTRIES; i++) begin
            if (impl[i] && !ent[i][MASK_BIT] && active[i]
                && ent[i][MODE_LSB +: MODE_W] == LST_MODE_FIXED
                && ent[i][VEC_LSB +: VEC_W] < VEC_FIRST_VALID) begin
                evt_illegal = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            illegal_vector_o <= 1'b0;
        end else begin
            illegal_vector_o <= (|wr_illegal) || evt_illegal;
        end
    end

    // ==========================================
    // Register read
    // ==========================================
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h00000000;
        if (ver_hit) begin
            next_rdata[VER_LSB +: 8] = VERSION_CODE;
            next_rdata[LAST_IDX_LSB +: 8] = LAST_INDEX;
            next_rdata[EOI_SUPP_BIT] = EOI_SUPPRESS_OK;
        end
        for (int i = 0; i < NUM_ENTRIES; i++) begin
            if (hit[i]) begin
                next_rdata = ent[i];
                next_rdata[STATUS_BIT] = pending[i];
                next_rdata[REMOTE_BIT] = remote[i] && ENTRY_WR[i][TRIG_BIT];
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end
    end
endmodule // lst_table
`default_nettype wire

// ==== test/lst_core_model.sv ====
// Processor core model that accepts offered deliveries
`default_nettype none
module lst_core_model (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic irq_valid_i,
    input wire logic [3:0] accept_delay_i,
    output logic irq_accept_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_cnt;
    // Accept one offer after the set wait, then let go
    always @(negedge sys_clk_i) begin
        if (!resetn_i) begin
            wait_cnt <= 4'h0;
            irq_accept_o <= 1'b0;
        end else if (irq_valid_i && !irq_accept_o && wait_cnt >= accept_delay_i) begin
            irq_accept_o <= 1'b1;
        end else begin
            irq_accept_o <= 1'b0;
            wait_cnt <= (irq_valid_i && !irq_accept_o) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule // lst_core_model
`default_nettype wire

// ==== test/lst_table_properties.sv ====
// Port assertions for the local source table
`default_nettype none
module lst_table_properties #(
    parameter int HAS_THERMAL = 1,
    parameter logic EOI_SUPPRESS_OK = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [31:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic irq_valid_o,
    input wire logic [7:0] irq_vector_o,
    input wire lst_pkg::lst_mode_t irq_mode_o,
    input wire logic [2:0] irq_src_o,
    input wire logic irq_accept_i,
    input wire logic acknowledge_cycle_o,
    input wire logic timer_periodic_o
);
    import lst_pkg::*;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    logic take_ext;
    logic per_bit;
    logic [7:0] last_idx;
    assign take_ext = irq_valid_o && irq_accept_i && irq_mode_o == LST_MODE_EXT;
    assign per_bit = reg_wdata_i[TMODE_BIT];
    assign last_idx = (HAS_THERMAL != 0) ? 8'h06 : 8'h05;
    // ==========================================
    // Delivery handshake, reset, version read and timer mode bit
    // ==========================================
    sequence s_offer; irq_valid_o && !irq_accept_i; endsequence
    sequence s_take; irq_valid_o && irq_accept_i; endsequence
    offer_hold_a: assert property (s_offer |=> irq_valid_o && $stable(irq_vector_o) && $stable(irq_src_o))
        else $error("offer changed before accept");
    take_drop_a: assert property (s_take |=> !irq_valid_o)
        else $error("offer stayed after accept");
    ext_ack_a: assert property (s_take ##0 irq_mode_o == LST_MODE_EXT |=> acknowledge_cycle_o)
        else $error("no acknowledge cycle");
    ack_cause_a: assert property (acknowledge_cycle_o |-> $past(take_ext))
        else $error("acknowledge cycle without cause");
    other_vec_a: assert property (irq_valid_o && irq_mode_o != LST_MODE_FIXED |-> irq_vector_o == 8'h00)
        else $error("vector not zero in non-fixed mode");
    fixed_vec_a: assert property (irq_valid_o && irq_mode_o == LST_MODE_FIXED |-> irq_vector_o >= VEC_FIRST_VALID)
        else $error("illegal vector delivered");
    mode_legal_a: assert property (irq_valid_o |-> irq_mode_o inside {3'b000, 3'b010, 3'b100, 3'b101, 3'b111})
        else $error("reserved mode delivered");
    reset_idle_a: assert property ($rose(resetn_i) |-> !irq_valid_o && !acknowledge_cycle_o)
        else $error("outputs busy after reset");
    version_rd_a: assert property (reg_rd_i && reg_addr_i == ADDR_VERSION |=> reg_rdata_o[23:16] == last_idx
        && reg_rdata_o[EOI_SUPP_BIT] == EOI_SUPPRESS_OK && reg_rdata_o[7:0] < VER_RESERVED_FIRST)
        else $error("version fields wrong");
    timer_mode_a: assert property (reg_wr_i && reg_addr_i == ADDR_TIMER |=> timer_periodic_o == $past(per_bit))
        else $error("timer mode bit not taken");
endmodule // lst_table_properties

bind lst_table lst_table_properties #(.HAS_THERMAL(HAS_THERMAL), .EOI_SUPPRESS_OK(EOI_SUPPRESS_OK))
    lst_table_properties_i (.sys_clk_i, .resetn_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .irq_valid_o, .irq_vector_o, .irq_mode_o, .irq_src_o, .irq_accept_i,
    .acknowledge_cycle_o, .timer_periodic_o);
`default_nettype wire

// ==== test/test_lst_table.sv ====
// Testbench for the local source table
`default_nettype none
module test_lst_table;
    timeunit 1ns;
    timeprecision 1ps;
    import lst_pkg::*;
    logic sys_clk_i = 0, resetn_i = 0, wr = 0, rd = 0, sw_en = 1, tied = 0, prf = 0, err = 0, cerr = 0;
    logic pin1 = 1, end_of_interrupt_message = 0, valid, ack, ill, tper, accept, ack_seen = 0, noio = 0, tmr = 0, thm = 0;
    logic [31:0] addr = 0, wdata = 0, rdata, rv;
    logic [7:0] vec, eoi_vec = 0;
    logic [2:0] src;
    logic [2:0] modes [6] = '{3'b000, 3'b010, 3'b100, 3'b101, 3'b111, 3'b001};
    lst_mode_t mode;
    int num_errors = 0, num_checks = 0, cycles = 0, ill_count = 0, ill_base = 0;
    always #2 sys_clk_i = ~sys_clk_i;
    lst_table lst_table_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .sw_enable_i(sw_en), .no_io_ctrl_i(noio),
        .timer_evt_i(tmr), .thermal_evt_i(thm), .perf_evt_i(prf), .error_evt_i(err),
        .corrected_error_threshold_irq_i(cerr), .local_irq_pin0_i(tied), .local_irq_pin1_i(pin1),
        .irq_valid_o(valid), .irq_vector_o(vec), .irq_mode_o(mode), .irq_src_o(src), .irq_accept_i(accept),
        .acknowledge_cycle_o(ack), .end_of_interrupt_message_i(end_of_interrupt_message), .eoi_vector_i(eoi_vec),
        .illegal_vector_o(ill), .timer_periodic_o(tper));
    lst_core_model lst_core_model_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .irq_valid_i(valid),
        .accept_delay_i(4'h8), .irq_accept_o(accept));
    // ==========================================
    // Tasks
    // ==========================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(negedge sys_clk_i);
        addr = a;
        wdata = d;
        wr = 1;
        @(negedge sys_clk_i);
        wr = 0;
    endtask
    task automatic rd_reg(input logic [31:0] a);
        @(negedge sys_clk_i);
        addr = a;
        rd = 1;
        @(negedge sys_clk_i);
        rd = 0;
        rv = rdata;
    endtask
    task automatic wait_valid(input logic exp);
        int n;
        n = 0;
        while (valid !== 1'b1 && n < 12) begin
            @(negedge sys_clk_i);
            n++;
        end
        check({31'h0, valid}, {31'h0, exp});
    endtask
    task automatic wait_drop;
        int n;
        n = 0;
        while (valid !== 1'b0 && n < 20) begin
            @(negedge sys_clk_i);
            n++;
        end
    endtask
    task automatic close_out;
        $display("Errors: %0d, checks: %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================
    // Timeout and illegal vector watch
    // ==========================================
    always @(posedge sys_clk_i) begin
        cycles++;
        if (ill === 1'b1) ill_count++;
        if (ack === 1'b1) ack_seen <= 1'b1;
        if (cycles == 5000) begin
            num_errors++;
            close_out();
        end
    end
    // ==========================================
    // Tests
    // ==========================================
    initial begin
        repeat (16) @(negedge sys_clk_i);
        resetn_i = 1;
        for (int i = 0; i < NUM_ENTRIES; i++) begin
            rd_reg(ENTRY_ADDR[i]);
            check(rv, ENTRY_RESET);
            wr_reg(ENTRY_ADDR[i], 32'hffffffff);
            rd_reg(ENTRY_ADDR[i]);
            check(rv, ENTRY_WR[i]);
            wr_reg(ENTRY_ADDR[i], ENTRY_RESET);
        end
        wr_reg(ADDR_TIMER, 32'h00030000);
        check({31'h0, tper}, 32'h1);
        rd_reg(ADDR_VERSION);
        check({24'h0, rv[23:16]}, 32'h6);
        check({31'h0, rv[EOI_SUPP_BIT]}, 32'h1);
        check({31'h0, rv[7:0] < VER_RESERVED_FIRST}, 32'h1);
        rd_reg(32'hfee00380);
        check(rv, 32'h0);
        for (int m = 0; m < 6; m++) begin
            wr_reg(ADDR_CERR, {21'h0, modes[m], 8'h10});
            @(negedge sys_clk_i);
            cerr = 1;
            @(negedge sys_clk_i);
            cerr = 0;
            wait_valid(m < 5);
            if (m < 5) begin
                check({24'h0, vec}, (m == 0) ? 32'h10 : 32'h0);
                check({29'h0, mode}, {29'h0, modes[m]});
                check({29'h0, src}, 32'h0);
                rd_reg(ADDR_CERR);
                check({31'h0, rv[STATUS_BIT]}, 32'h1);
                wait_drop();
                rd_reg(ADDR_CERR);
                check({31'h0, rv[STATUS_BIT]}, 32'h0);
                check({31'h0, ack_seen}, {31'h0, m == 4});
            end
        end
        wr_reg(ADDR_CERR, 32'h00010040);
        @(negedge sys_clk_i);
        cerr = 1;
        @(negedge sys_clk_i);
        cerr = 0;
        wait_valid(0);
        rd_reg(ADDR_CERR);
        check({31'h0, rv[STATUS_BIT]}, 32'h0);
        ill_base = ill_count;
        wr_reg(ADDR_ERR, 32'h00000005);
        @(negedge sys_clk_i);
        check(ill_count - ill_base, 32'h1);
        ill_base = ill_count;
        err = 1;
        @(negedge sys_clk_i);
        err = 0;
        wait_valid(0);
        check(ill_count - ill_base, 32'h1);
        wr_reg(ADDR_PERF, 32'h00000030);
        @(negedge sys_clk_i);
        prf = 1;
        @(negedge sys_clk_i);
        prf = 0;
        wait_valid(1);
        wait_drop();
        rd_reg(ADDR_PERF);
        check(rv, 32'h00010030);
        // Timer and thermal at once: lower index is offered first
        wr_reg(ADDR_TIMER, 32'h00000021);
        wr_reg(ADDR_THERM, 32'h00000022);
        @(negedge sys_clk_i);
        tmr = 1;
        thm = 1;
        @(negedge sys_clk_i);
        tmr = 0;
        thm = 0;
        wait_valid(1);
        check({29'h0, src}, 32'h1);
        wait_drop();
        wait_valid(1);
        check({29'h0, src}, 32'h2);
        check({24'h0, vec}, 32'h22);
        wait_drop();
        wr_reg(ADDR_PIN1, 32'h0000a050);
        pin1 = 0;
        wait_valid(1);
        check({29'h0, src}, 32'h5);
        wait_drop();
        pin1 = 1;
        rd_reg(ADDR_PIN1);
        check({31'h0, rv[REMOTE_BIT]}, 32'h1);
        @(negedge sys_clk_i);
        end_of_interrupt_message = 1;
        eoi_vec = 8'h50;
        @(negedge sys_clk_i);
        end_of_interrupt_message = 0;
        rd_reg(ADDR_PIN1);
        check({31'h0, rv[REMOTE_BIT]}, 32'h0);
        check({31'h0, valid}, 32'h0);
        // Edge pin entry, then the same with no external controller
        for (int k = 0; k < 2; k++) begin
            noio = (k == 1);
            wr_reg(ADDR_PIN1, 32'h00002060);
            pin1 = 0;
            wait_valid(1);
            wait_drop();
            wait_valid(0);
            rd_reg(ADDR_PIN1);
            check({31'h0, rv[REMOTE_BIT]}, {31'h0, k == 1});
            pin1 = 1;
            repeat (3) @(negedge sys_clk_i);
            end_of_interrupt_message = 1;
            eoi_vec = 8'h60;
            @(negedge sys_clk_i);
            end_of_interrupt_message = 0;
        end
        sw_en = 0;
        wr_reg(ADDR_PIN0, 32'h0);
        rd_reg(ADDR_PIN0);
        check({31'h0, rv[MASK_BIT]}, 32'h1);
        sw_en = 1;
        close_out();
    end
endmodule // test_lst_table
`default_nettype wire
